// file: core/dhm_map.svh
// constants of the detector host message handler: codes, layout, timing
`ifndef DHM_MAP_SVH
`define DHM_MAP_SVH
`define DHM_CLK_HZ      125000000
`define DHM_TEST_S      15
`define DHM_POLL_TO_S   300
`define DHM_PAT_BAUD    1200
`define DHM_HDR_LEN     4'ha
`define DHM_ADDR_LEN    4'h8
`define DHM_LF          8'h0a
`define DHM_PAD         8'h20
`define DHM_MAX_AXLES   6'h28
`define DHM_ACK_TRIES   3'h5
`define DHM_C_INIT_COLD 16'h4943
`define DHM_C_INIT_WARM 16'h4957
`define DHM_C_T_CARR    16'h4a43
`define DHM_C_T_MARK    16'h4a4d
`define DHM_C_T_PAT     16'h4a50
`define DHM_C_T_SPACE   16'h4a53
`define DHM_C_LIST_DEF  16'h4c44
`define DHM_C_LIST_ALL  16'h4c54
`define DHM_C_RESEND    16'h5241
`define DHM_C_HEAT_REQ  16'h5242
`define DHM_C_SET_LOC   16'h534c
`define DHM_C_SET_MODEM 16'h534d
`define DHM_C_SET_ALARM 16'h5351
`define DHM_C_STRESS    16'h5352
`define DHM_C_PARAM_REQ 16'h5358
`define DHM_C_TIME_RD   16'h5452
`define DHM_C_SET_TIME  16'h5453
`define DHM_C_TEST_TRN  16'h5454
`define DHM_C_WX_RD     16'h5752
`define DHM_C_PWR_UP    16'h4950
`define DHM_C_TR_START  16'h5a41
`define DHM_C_TR_AXLE   16'h5a42
`define DHM_C_TR_WHEEL  16'h5a43
`define DHM_C_TR_HEAT   16'h5a45
`define DHM_C_TR_END    16'h5a55
`define DHM_C_TR_FINAL  16'h5a5a
`endif

// file: core/dhm_pkg.sv
// types of the detector host message handler
package dhm_pkg;
  typedef logic [15:0] dhm_code_t;
  typedef struct packed {
    dhm_code_t  code;
    logic [5:0] axles;
    logic       has_text;
  } dhm_snd_t;
  typedef struct packed {
    dhm_code_t  kind;
    logic [7:0] data;
  } dhm_set_t;
  typedef enum logic [2:0] {
    DHM_L_IDLE = 3'b000, DHM_L_MARK = 3'b001, DHM_L_SPACE = 3'b010,
    DHM_L_CARR = 3'b011, DHM_L_PAT = 3'b100
  } dhm_line_t;
  typedef enum logic [1:0] {
    DHM_F_IDLE = 2'b00, DHM_F_HDR = 2'b01, DHM_F_TXT = 2'b10, DHM_F_LF = 2'b11
  } dhm_fmt_t;
  typedef enum logic [1:0] {
    DHM_T_NONE = 2'b00, DHM_T_OPEN = 2'b01, DHM_T_AXLE = 2'b10, DHM_T_END = 2'b11
  } dhm_train_t;
endpackage

// file: core/dhm_handler.sv
// detector host message handler with its outgoing byte fifo
`timescale 1ns/1ps
`include "dhm_map.svh"

module dhm_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_reg [D];
  logic [AW:0]  wr_reg;
  logic [AW:0]  rd_reg;
  logic         push;
  logic         pop;

  // full when pointers differ only in the wrap bit
  assign in_ready  = (wr_reg ^ rd_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_reg != rd_reg;
  assign out_data  = mem_reg[rd_reg[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage has no reset, only the pointers matter
  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wr_reg[AW-1:0]] <= in_data;
  end

  // pointers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule

module dhm_handler #(
  parameter logic [31:0] TEST_CYC    = 32'(`DHM_TEST_S * `DHM_CLK_HZ),
  parameter logic [35:0] POLL_TO_CYC = 36'(64'(`DHM_POLL_TO_S) * 64'(`DHM_CLK_HZ)),
  parameter bit          DUAL_SUPPORTED = 1'b1
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                poll_mode,
  input  wire logic                fmt_7e1,
  input  wire logic [7:0]          addr_letter,
  input  wire logic [7:0][7:0]     site_name,
  input  wire logic                talker_cfg,
  input  wire logic                rx_valid,
  input  wire logic [7:0]          rx_data,
  output logic                     init_cold,
  output logic                     init_warm,
  output logic                     req_valid,
  output dhm_pkg::dhm_code_t       req_code,
  output logic                     set_valid,
  output dhm_pkg::dhm_set_t        set_word,
  output logic                     set_done,
  output logic                     line_test,
  output logic                     line_level,
  output logic                     carrier_on,
  input  wire logic                snd_valid,
  output logic                     snd_ready,
  input  wire dhm_pkg::dhm_snd_t   snd_hdr,
  output logic                     snd_reject,
  input  wire logic                txt_valid,
  output logic                     txt_ready,
  input  wire logic [7:0]          txt_data,
  input  wire logic                txt_last,
  input  wire logic                ack_ok,
  input  wire logic                ack_miss,
  input  wire logic                train_done,
  input  wire logic                train_defect,
  output logic                     announce,
  output logic                     announce_always,
  output logic                     tx_valid,
  input  wire logic                tx_ready,
  output logic [7:0]               tx_data
);
  localparam logic [16:0] PAT_HALF = 17'(`DHM_CLK_HZ / `DHM_PAT_BAUD);

  // receive side
  logic [7:0]         rx_b;
  logic [3:0]         ridx_reg;
  logic               match_reg;
  dhm_pkg::dhm_code_t rtype_reg;
  logic [7:0]         addr_exp;
  logic               rx_end;
  logic               is_set;
  // line test
  dhm_pkg::dhm_line_t line_reg;
  logic [31:0]        tcnt_reg;
  logic [16:0]        pcnt_reg;
  logic               pat_reg;
  logic               test_go;
  dhm_pkg::dhm_line_t test_sel;
  // policy
  logic [35:0]        pto_cnt_reg;
  logic               poll_to_reg;
  logic               ack_fail_reg;
  logic [2:0]         miss_reg;
  logic               talker_reg;
  logic               saved_reg;
  logic               forced_q_reg;
  logic               forced;
  // transmit side
  dhm_pkg::dhm_fmt_t   fst_reg;
  dhm_pkg::dhm_train_t train_reg;
  dhm_pkg::dhm_snd_t   cur_reg;
  logic [3:0]          hidx_reg;
  logic                drop_reg;
  logic                ip_pend_reg;
  logic                rb_pend_reg;
  logic                rb_seen;
  logic                take;
  logic                ok;
  logic                f_valid;
  logic                f_ready;
  logic [7:0]          f_byte;
  logic [7:0]          h_byte;

  // seven-bit format strips the parity position from every byte
  assign rx_b = fmt_7e1 ? {1'b0, rx_data[6:0]} : rx_data;

  // dial-in compares the whole site name, polling only the letter
  always_comb
  begin
    if (poll_mode)
      addr_exp = (ridx_reg == 4'h0) ? addr_letter : rx_b;
    else
      addr_exp = site_name[3'(3'h7 - ridx_reg[2:0])];
  end

  assign rx_end = rx_valid & (rx_b == `DHM_LF);
  assign is_set = (rtype_reg == `DHM_C_SET_LOC) | (rtype_reg == `DHM_C_SET_ALARM)
                | (rtype_reg == `DHM_C_SET_TIME);

  // header walk: address bytes, then the two type bytes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ridx_reg  <= 4'h0;
      match_reg <= 1'b1;
      rtype_reg <= 16'h0000;
    end
    else if (rx_end)
    begin
      ridx_reg  <= 4'h0;
      match_reg <= 1'b1;
    end
    else if (rx_valid && ridx_reg < `DHM_HDR_LEN)
    begin
      ridx_reg <= ridx_reg + 4'h1;
      if (ridx_reg < `DHM_ADDR_LEN && rx_b != addr_exp)
        match_reg <= 1'b0;
      if (ridx_reg == `DHM_ADDR_LEN)
        rtype_reg[15:8] <= rx_b;
      if (ridx_reg == `DHM_ADDR_LEN + 4'h1)
        rtype_reg[7:0] <= rx_b;
    end
  end

  // text of a settings write streams straight out
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      set_valid <= 1'b0;
      set_word  <= '0;
    end
    else
    begin
      set_valid <= rx_valid & ~rx_end & match_reg & is_set
                 & (ridx_reg == `DHM_HDR_LEN);
      if (rx_valid)
        set_word <= '{kind: rtype_reg, data: rx_b};
    end
  end

  // dispatch at the linefeed of a complete, addressed message
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      init_cold <= 1'b0;
      init_warm <= 1'b0;
      req_valid <= 1'b0;
      req_code  <= 16'h0000;
      set_done  <= 1'b0;
    end
    else
    begin
      init_cold <= 1'b0;
      init_warm <= 1'b0;
      req_valid <= 1'b0;
      set_done  <= 1'b0;
      if (rx_end && match_reg && ridx_reg == `DHM_HDR_LEN)
      begin
        req_code <= rtype_reg;
        case (rtype_reg)
          `DHM_C_INIT_COLD: init_cold <= 1'b1;
          `DHM_C_INIT_WARM: init_warm <= 1'b1;
          `DHM_C_LIST_DEF, `DHM_C_LIST_ALL: req_valid <= 1'b1;
          `DHM_C_TIME_RD: req_valid <= 1'b1;
          `DHM_C_PARAM_REQ: req_valid <= 1'b1;
          `DHM_C_WX_RD: req_valid <= 1'b1;
          `DHM_C_RESEND, `DHM_C_SET_MODEM: req_valid <= 1'b1;
          `DHM_C_HEAT_REQ, `DHM_C_STRESS, `DHM_C_TEST_TRN:
            req_valid <= DUAL_SUPPORTED;
          `DHM_C_SET_LOC, `DHM_C_SET_ALARM, `DHM_C_SET_TIME:
            set_done <= 1'b1;
          default: ; // foreign types: silence
        endcase
      end
    end
  end

  assign rb_seen = rx_end & match_reg & (ridx_reg == `DHM_HDR_LEN)
                 & (rtype_reg == `DHM_C_HEAT_REQ) & DUAL_SUPPORTED;

  // line test selection from a finished test request
  always_comb
  begin
    test_go  = rx_end & match_reg & (ridx_reg == `DHM_HDR_LEN);
    test_sel = dhm_pkg::DHM_L_IDLE;
    case (rtype_reg)
      `DHM_C_T_MARK:  test_sel = dhm_pkg::DHM_L_MARK;
      `DHM_C_T_SPACE: test_sel = dhm_pkg::DHM_L_SPACE;
      `DHM_C_T_CARR:  test_sel = dhm_pkg::DHM_L_CARR;
      `DHM_C_T_PAT:   test_sel = dhm_pkg::DHM_L_PAT;
      default:        test_go  = 1'b0;
    endcase
  end

  // fixed-length test, a new request restarts the interval
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_reg <= dhm_pkg::DHM_L_IDLE;
      tcnt_reg <= 32'h0;
    end
    else if (test_go)
    begin
      line_reg <= test_sel;
      tcnt_reg <= TEST_CYC - 32'h1;
    end
    else if (line_reg != dhm_pkg::DHM_L_IDLE)
    begin
      if (tcnt_reg == 32'h0)
        line_reg <= dhm_pkg::DHM_L_IDLE; // stops after 15 s
      else
        tcnt_reg <= tcnt_reg - 32'h1;
    end
  end

  // pattern toggles at a slow bit rate the modem can pass
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pcnt_reg <= 17'h0;
      pat_reg  <= 1'b1;
    end
    else if (line_reg != dhm_pkg::DHM_L_PAT)
    begin
      pcnt_reg <= 17'h0;
      pat_reg  <= 1'b1;
    end
    else if (pcnt_reg == PAT_HALF - 17'h1)
    begin
      pcnt_reg <= 17'h0;
      pat_reg  <= ~pat_reg;
    end
    else
      pcnt_reg <= pcnt_reg + 17'h1;
  end

  // idle line rests at mark
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_test  <= 1'b0;
      line_level <= 1'b1;
      carrier_on <= 1'b0;
    end
    else
    begin
      line_test  <= line_reg != dhm_pkg::DHM_L_IDLE;
      carrier_on <= line_reg == dhm_pkg::DHM_L_CARR;
      case (line_reg)
        dhm_pkg::DHM_L_SPACE: line_level <= 1'b0;
        dhm_pkg::DHM_L_PAT:   line_level <= pat_reg;
        default:              line_level <= 1'b1;
      endcase
    end
  end

  // poll watchdog, only while polled standalone
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pto_cnt_reg <= 36'h0;
      poll_to_reg <= 1'b0;
    end
    else if (!poll_mode || (rx_end && match_reg && ridx_reg == `DHM_HDR_LEN))
    begin
      pto_cnt_reg <= 36'h0;
      poll_to_reg <= 1'b0;
    end
    else if (pto_cnt_reg == POLL_TO_CYC - 36'h1)
      poll_to_reg <= 1'b1;
    else
      pto_cnt_reg <= pto_cnt_reg + 36'h1;
  end

  // unanswered start/end sends; a miss in the ack cycle still counts
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      miss_reg     <= 3'h0;
      ack_fail_reg <= 1'b0;
    end
    else if (!poll_mode)
    begin
      miss_reg     <= 3'h0;
      ack_fail_reg <= 1'b0;
    end
    else if (ack_miss)
    begin
      if (miss_reg == `DHM_ACK_TRIES - 3'h1)
        ack_fail_reg <= 1'b1;
      else
        miss_reg <= miss_reg + 3'h1;
    end
    else if (ack_ok)
    begin
      miss_reg     <= 3'h0;
      ack_fail_reg <= 1'b0;
    end
  end

  assign forced = poll_to_reg | ack_fail_reg;

  // policy saved on entry to forced mode, restored once both faults clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      talker_reg   <= 1'b0;
      saved_reg    <= 1'b0;
      forced_q_reg <= 1'b0;
    end
    else
    begin
      forced_q_reg <= forced;
      if (forced && !forced_q_reg)
      begin
        saved_reg  <= talker_reg; // kept apart from the flags
        talker_reg <= 1'b1; // already always: same value
      end
      else if (!forced && forced_q_reg)
        talker_reg <= saved_reg;
      else if (!forced)
        talker_reg <= talker_cfg;
    end
  end

  // announcement decision per finished train
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      announce <= 1'b0;
    else
      announce <= train_done & (train_defect | talker_reg);
  end

  assign announce_always = talker_reg;

  // order checks on outgoing train traffic; resends of start/end allowed
  always_comb
  begin
    case (snd_hdr.code)
      `DHM_C_TR_START: ok = (train_reg == dhm_pkg::DHM_T_NONE)
                          | (train_reg == dhm_pkg::DHM_T_OPEN);
      `DHM_C_TR_AXLE:  ok = (train_reg == dhm_pkg::DHM_T_OPEN)
                          | (train_reg == dhm_pkg::DHM_T_AXLE);
      `DHM_C_TR_WHEEL: ok = (train_reg == dhm_pkg::DHM_T_AXLE)
                          & (snd_hdr.axles <= `DHM_MAX_AXLES)
                          & (snd_hdr.axles != 6'h0);
      `DHM_C_TR_END:   ok = train_reg != dhm_pkg::DHM_T_NONE;
      `DHM_C_TR_FINAL: ok = train_reg == dhm_pkg::DHM_T_END;
      `DHM_C_TR_HEAT:  ok = rb_pend_reg;
      default:         ok = 1'b1;
    endcase
  end

  assign snd_ready = (fst_reg == dhm_pkg::DHM_F_IDLE) & ~ip_pend_reg;
  assign take      = snd_valid & snd_ready;

  // train sequence tracking on accepted messages
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      train_reg <= dhm_pkg::DHM_T_NONE;
    else if (take && ok)
    begin
      case (snd_hdr.code)
        `DHM_C_TR_START: train_reg <= dhm_pkg::DHM_T_OPEN;
        `DHM_C_TR_AXLE:  train_reg <= dhm_pkg::DHM_T_AXLE;
        `DHM_C_TR_END:   train_reg <= dhm_pkg::DHM_T_END;
        `DHM_C_TR_FINAL: train_reg <= dhm_pkg::DHM_T_NONE;
        default:         train_reg <= train_reg;
      endcase
    end
  end

  // heat request pending; a new request beats the clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rb_pend_reg <= 1'b0;
    else if (rb_seen)
      rb_pend_reg <= 1'b1;
    else if (take && ok && snd_hdr.code == `DHM_C_TR_HEAT)
      rb_pend_reg <= 1'b0;
  end

  // framer state: header, optional text, linefeed
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fst_reg     <= dhm_pkg::DHM_F_IDLE;
      cur_reg     <= '0;
      hidx_reg    <= 4'h0;
      drop_reg    <= 1'b0;
      ip_pend_reg <= 1'b1; // power-up report queued
      snd_reject  <= 1'b0;
    end
    else
    begin
      snd_reject <= take & ~ok;
      case (fst_reg)
        dhm_pkg::DHM_F_IDLE:
        begin
          hidx_reg <= 4'h0;
          drop_reg <= 1'b0;
          if (ip_pend_reg)
          begin
            ip_pend_reg <= 1'b0;
            cur_reg     <= '{code: `DHM_C_PWR_UP, axles: 6'h0, has_text: 1'b0};
            fst_reg     <= dhm_pkg::DHM_F_HDR;
          end
          else if (take)
          begin
            cur_reg  <= snd_hdr;
            drop_reg <= ~ok;
            if (ok)
              fst_reg <= dhm_pkg::DHM_F_HDR;
            else if (snd_hdr.has_text)
              fst_reg <= dhm_pkg::DHM_F_TXT; // swallow refused text
          end
        end
        dhm_pkg::DHM_F_HDR:
          if (f_ready)
          begin
            hidx_reg <= hidx_reg + 4'h1;
            if (hidx_reg == `DHM_HDR_LEN - 4'h1)
              fst_reg <= cur_reg.has_text ? dhm_pkg::DHM_F_TXT
                                          : dhm_pkg::DHM_F_LF;
          end
        dhm_pkg::DHM_F_TXT:
          if (txt_valid && txt_ready && txt_last)
            fst_reg <= drop_reg ? dhm_pkg::DHM_F_IDLE : dhm_pkg::DHM_F_LF;
        dhm_pkg::DHM_F_LF:
          if (f_ready)
            fst_reg <= dhm_pkg::DHM_F_IDLE;
        default: fst_reg <= dhm_pkg::DHM_F_IDLE;
      endcase
    end
  end

  // header bytes: own address, then the two type characters
  always_comb
  begin
    if (hidx_reg == `DHM_ADDR_LEN)
      h_byte = cur_reg.code[15:8];
    else if (hidx_reg == `DHM_ADDR_LEN + 4'h1)
      h_byte = cur_reg.code[7:0];
    else if (poll_mode)
      h_byte = (hidx_reg == 4'h0) ? addr_letter : `DHM_PAD;
    else
      h_byte = site_name[3'(3'h7 - hidx_reg[2:0])];
  end

  // byte offered to the fifo; stalls reach txt_ready
  always_comb
  begin
    f_valid = 1'b0;
    f_byte  = `DHM_LF;
    case (fst_reg)
      dhm_pkg::DHM_F_HDR:
      begin
        f_valid = 1'b1;
        f_byte  = h_byte;
      end
      dhm_pkg::DHM_F_TXT:
      begin
        f_valid = txt_valid & ~drop_reg;
        f_byte  = txt_data;
      end
      dhm_pkg::DHM_F_LF: f_valid = 1'b1;
      default: f_valid = 1'b0;
    endcase
    if (fmt_7e1)
      f_byte = {1'b0, f_byte[6:0]};
  end

  assign txt_ready = (fst_reg == dhm_pkg::DHM_F_TXT) & (drop_reg | f_ready);

  dhm_fifo #(
    .W (8),
    .D (8)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .in_data   (f_byte),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );
endmodule

// file: sim/dhm_host_model.sv
// host side model: drains device bytes with random stalls
`timescale 1ns/1ps
module dhm_host_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [7:0]  got [$];
  logic [15:0] lf_reg;
  // a slow host stalls on random cycles so the fifo backs up
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      lf_reg   <= 16'h5a5a;
      tx_ready <= 1'b0;
    end
    else
    begin
      lf_reg   <= {lf_reg[14:0], lf_reg[15] ^ lf_reg[13] ^ lf_reg[12] ^ lf_reg[10]};
      tx_ready <= lf_reg[0] | lf_reg[3];
      if (tx_valid && tx_ready)
        got.push_back(tx_data);
    end
endmodule

// file: sim/dhm_handler_sva.sv
// port assertions of the detector host message handler
`timescale 1ns/1ps
`include "dhm_map.svh"
module dhm_handler_sva (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              fmt_7e1,
  input wire logic              init_cold,
  input wire logic              init_warm,
  input wire logic              line_test,
  input wire logic              snd_valid,
  input wire logic              snd_ready,
  input wire dhm_pkg::dhm_snd_t snd_hdr,
  input wire logic              snd_reject,
  input wire logic              train_done,
  input wire logic              train_defect,
  input wire logic              announce,
  input wire logic              announce_always,
  input wire logic              tx_valid,
  input wire logic              tx_ready,
  input wire logic [7:0]        tx_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a send is taken when both sides agree
  sequence s_take;
    snd_valid && snd_ready;
  endsequence
  sequence s_big_wheel;
    s_take ##0 (snd_hdr.code == `DHM_C_TR_WHEEL && snd_hdr.axles > `DHM_MAX_AXLES);
  endsequence
  property p_init_pulse;
    init_cold || init_warm |=> !init_cold && !init_warm;
  endproperty
  a_init_pulse: assert property (p_init_pulse) else $error("init pulse too long");
  property p_test_holds;
    $rose(line_test) |-> line_test [*8];
  endproperty
  a_test_holds: assert property (p_test_holds) else $error("line test cut short");
  property p_one_msg;
    s_take |=> !snd_ready;
  endproperty
  a_one_msg: assert property (p_one_msg) else $error("second send accepted");
  property p_wheel_cap;
    s_big_wheel |=> snd_reject;
  endproperty
  a_wheel_cap: assert property (p_wheel_cap) else $error("wheel over cap accepted");
  property p_ann_yes;
    train_done && (train_defect || announce_always) |=> announce;
  endproperty
  a_ann_yes: assert property (p_ann_yes) else $error("announcement missing");
  property p_ann_no;
    !(train_done && (train_defect || announce_always)) |=> !announce;
  endproperty
  a_ann_no: assert property (p_ann_no) else $error("unexpected announcement");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte lost under stall");
  property p_seven_bit;
    fmt_7e1 && tx_valid |-> !tx_data[7];
  endproperty
  a_seven_bit: assert property (p_seven_bit) else $error("bit 7 set in 7e1");
endmodule

// file: sim/test_dhm_handler.sv
// self-checking bench of the detector host message handler
`timescale 1ns/1ps
`include "dhm_map.svh"
module test_dhm_handler;
  logic clk = 1'b0, rst_n = 1'b0, rx_valid = 1'b0, snd_valid = 1'b0, txt_valid = 1'b0;
  logic ack_ok = 1'b0, ack_miss = 1'b0, talker_cfg = 1'b0, train_done = 1'b0;
  logic train_defect = 1'b0, fmt_7e1 = 1'b1;
  logic [7:0] rx_data = 8'h00, txt_data = 8'h00, tx_data;
  logic [15:0] lf = 16'ha963;
  dhm_pkg::dhm_snd_t snd_hdr = '0;
  dhm_pkg::dhm_code_t req_code;
  logic init_cold, init_warm, req_valid, set_valid, set_done, line_test, line_level;
  logic carrier_on, snd_ready, snd_reject, txt_ready, announce, announce_always;
  logic tx_valid, tx_ready;
  int err_total = 0, compares = 0, k;
  int cnt [5] = '{default: 0};
  int base [5];
  logic [15:0] hc [18] = '{`DHM_C_INIT_COLD, `DHM_C_INIT_WARM, `DHM_C_LIST_DEF,
    `DHM_C_LIST_ALL, `DHM_C_PARAM_REQ, `DHM_C_TIME_RD, `DHM_C_WX_RD, `DHM_C_SET_MODEM,
    `DHM_C_RESEND, `DHM_C_SET_LOC, `DHM_C_SET_ALARM, `DHM_C_SET_TIME, 16'h4d52,
    16'h5052, 16'h5057, 16'h4857, 16'h534e, 16'h544f};
  logic [15:0] dc [7] = '{`DHM_C_TR_AXLE, `DHM_C_TR_WHEEL, `DHM_C_TR_WHEEL,
    `DHM_C_TR_END, `DHM_C_TR_FINAL, `DHM_C_TR_HEAT, `DHM_C_TR_FINAL};
  dhm_handler #(.TEST_CYC(32'd200), .POLL_TO_CYC(36'd500)) dhm_handler_i (
    .clk, .rst_n, .poll_mode(1'b1), .fmt_7e1, .addr_letter(8'h41),
    .site_name({8{8'h53}}), .talker_cfg, .rx_valid, .rx_data, .init_cold, .init_warm,
    .req_valid, .req_code, .set_valid, .set_word(), .set_done, .line_test, .line_level,
    .carrier_on, .snd_valid, .snd_ready, .snd_hdr, .snd_reject, .txt_valid, .txt_ready,
    .txt_data, .txt_last(1'b1), .ack_ok, .ack_miss, .train_done, .train_defect,
    .announce, .announce_always, .tx_valid, .tx_ready, .tx_data
  );
  dhm_host_model dhm_host_model_i (.clk, .rst_n, .tx_valid, .tx_ready, .tx_data);
  function automatic logic [7:0] hdr_byte(input int i, input logic [15:0] c);
    return i == 0 ? 8'h41 : i < 8 ? 8'h20 : i == 8 ? c[15:8] : i == 9 ? c[7:0] : `DHM_LF;
  endfunction
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // clock and random train events
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    lf           <= lfsr(lf);
    train_done   <= rst_n & lf[0] & lf[4];
    train_defect <= lf[7];
  end
  // pulse tallies: cold, warm, request, settings byte plus settings done, reject
  always @(posedge clk)
  begin
    cnt[0] += (init_cold === 1'b1);
    cnt[1] += (init_warm === 1'b1);
    cnt[2] += (req_valid === 1'b1);
    cnt[3] += (set_valid === 1'b1) + (set_done === 1'b1);
    cnt[4] += (snd_reject === 1'b1);
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // host message: header, two non-linefeed text bytes, linefeed
  task automatic host_msg(input logic [15:0] c, input logic [7:0] a);
    for (int i = 0; i < 13; i++)
    begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= i == 0 ? a : (i < 10 || i == 12) ? hdr_byte(i, c) : lf[7:0] & 8'h7f | 8'h20;
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  // device message, one text byte, streamed even if refused
  task automatic dev_msg(input logic [15:0] c, input logic [5:0] ax, input int rej);
    base[4] = cnt[4];
    @(posedge clk);
    snd_valid <= 1'b1;
    snd_hdr   <= '{c, ax, 1'b1};
    k = 0;
    do @(negedge clk); while (snd_ready !== 1'b1 && ++k < 900);
    @(posedge clk);
    snd_valid <= 1'b0;
    txt_valid <= 1'b1;
    txt_data  <= lf[7:0] & 8'h7f;
    k = 0;
    do @(negedge clk); while (txt_ready !== 1'b1 && ++k < 900);
    @(posedge clk);
    txt_valid <= 1'b0;
    repeat (3) @(posedge clk);
    chk("snd_reject", 16'(cnt[4] - base[4]), 16'(rej));
  endtask
  task automatic chk_frame(input logic [15:0] c, input int n);
    for (k = 0; k < 300 && dhm_host_model_i.got.size() < n + 11; k++) @(posedge clk);
    for (int i = 0; i < n + 11; i++)
      if (i < 10 || i == n + 10)
        chk("tx byte", dhm_host_model_i.got[i], hdr_byte(i, c));
    dhm_host_model_i.got.delete();
  endtask
  task automatic ack_pulse(input logic miss, input int n);
    repeat (n)
    begin
      @(posedge clk);
      ack_miss <= miss;
      ack_ok   <= !miss;
      @(posedge clk);
      ack_miss <= 1'b0;
      ack_ok   <= 1'b0;
    end
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic report_and_stop;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard, far past the run length
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    chk_frame(`DHM_C_PWR_UP, 0);
    for (int t = 0; t < 18; t++)
    begin
      base = cnt;
      host_msg(hc[t], 8'h41);
      chk("cold", 16'(cnt[0] - base[0]), 16'(t == 0));
      chk("warm", 16'(cnt[1] - base[1]), 16'(t == 1));
      chk("request", 16'(cnt[2] - base[2]), 16'(t > 1 && t < 9));
      chk("settings", 16'(cnt[3] - base[3]), (t > 8 && t < 12) ? 16'h3 : 16'h0);
      if (t > 1 && t < 9)
        chk("code", req_code, hc[t]);
    end
    base = cnt;
    host_msg(`DHM_C_TIME_RD, 8'h42);
    chk("request", 16'(cnt[2] - base[2]), 16'h0);
    @(posedge clk) fmt_7e1 <= 1'b0;
    host_msg(`DHM_C_TIME_RD, 8'hc1);
    chk("request", 16'(cnt[2] - base[2]), 16'h0);
    host_msg(`DHM_C_T_MARK, 8'h41);
    chk("mark", {line_test, line_level}, 2'b11);
    host_msg(`DHM_C_T_SPACE, 8'h41);
    chk("space", {line_test, line_level}, 2'b10);
    host_msg(`DHM_C_T_PAT, 8'h41);
    chk("pattern", line_test, 1'b1);
    host_msg(`DHM_C_T_CARR, 8'h41);
    chk("carrier", {line_test, carrier_on}, 2'b11);
    repeat (220) @(negedge clk);
    chk("carrier", {line_test, carrier_on}, 2'b00);
    dev_msg(`DHM_C_TR_START, 6'h00, 0);
    chk_frame(`DHM_C_TR_START, 1);
    for (int t = 0; t < 7; t++)
      dev_msg(dc[t], t == 1 ? 6'h29 : 6'h28, int'(t == 1 || t > 4));
    host_msg(`DHM_C_TIME_RD, 8'h41);
    ack_pulse(1'b1, 4);
    chk("always", announce_always, 1'b0);
    ack_pulse(1'b1, 1);
    chk("always", announce_always, 1'b1);
    repeat (520) @(negedge clk);
    host_msg(`DHM_C_TIME_RD, 8'h41);
    chk("always", announce_always, 1'b1);
    ack_pulse(1'b0, 1);
    chk("always", announce_always, 1'b0);
    repeat (520) @(negedge clk);
    chk("always", announce_always, 1'b1);
    host_msg(`DHM_C_TIME_RD, 8'h41);
    chk("always", announce_always, 1'b0);
    @(posedge clk) talker_cfg <= 1'b1;
    repeat (520) @(negedge clk);
    chk("always", announce_always, 1'b1);
    @(posedge clk) talker_cfg <= 1'b0;
    host_msg(`DHM_C_TIME_RD, 8'h41);
    chk("always", announce_always, 1'b0);
    report_and_stop();
  end
endmodule
bind dhm_handler dhm_handler_sva dhm_handler_sva_i (
  .clk, .rst_n, .fmt_7e1, .init_cold, .init_warm, .line_test, .snd_valid, .snd_ready,
  .snd_hdr, .snd_reject, .train_done, .train_defect, .announce, .announce_always,
  .tx_valid, .tx_ready, .tx_data
);
